// ---- bench/pth_host.sv ----
// Host model driving the threshold register port
`timescale 1ns/100ps
module pth_host (
	// Clock
	input  wire       core_clk,
	// Read answer
	input  wire [7:0] reg_rdata,
	input  wire       reg_rvalid,
	// Request
	output reg        reg_wr,
	output reg        reg_rd,
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
	// Byte write; caller keeps measurements off meanwhile
	task wr(input [7:0] a, d);
		@(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
	endtask
	task rd(input [7:0] a, output [8:0] d);
		@(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge core_clk) {reg_rd, reg_addr} = {1'b0, ~a};
		d = {reg_rvalid, reg_rdata};
	endtask
endmodule

// ---- bench/pth_regs_assertions.sv ----
// Port checker for the threshold bank
`timescale 1ns/100ps
module pth_chk (
	// Clock and reset
	input wire        core_clk,
	input wire        rst,
	// Register port
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	input wire        reg_rvalid,
	// Variant and channel one measurement
	input wire        legacy_compressed,
	input wire        prox_ch1_valid,
	input wire [15:0] prox_ch1_result,
	// Outcomes and thresholds
	input wire [2:0]  prox_above,
	input wire [2:0]  prox_done,
	input wire        prox_irq_req,
	input wire [15:0] prox_ch1_threshold,
	input wire [15:0] prox_ch2_threshold
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_p2_low;
		reg_wr && reg_addr == 8'h13 |-> ##2 prox_ch2_threshold[7:0] == $past(reg_wdata, 2);
	endproperty
	a_p2_low: assert property (p_p2_low) else $error("ch2 low byte lost");
	property p_p1_high;
		reg_wr && reg_addr == 8'h12 && !legacy_compressed |-> ##2 prox_ch1_threshold[15:8] == $past(reg_wdata, 2);
	endproperty
	a_p1_high: assert property (p_p1_high) else $error("ch1 high byte lost");
	property p_legacy;
		legacy_compressed [*3] |-> prox_ch1_threshold[15:8] == 8'h00;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy high byte used");
	property p_rd;
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("no read answer");
	property p_rv;
		reg_rvalid |-> $past(reg_rd);
	endproperty
	a_rv: assert property (p_rv) else $error("stray read answer");
	property p_rd13;
		reg_rd && reg_addr == 8'h13 |=> reg_rdata == prox_ch2_threshold[7:0];
	endproperty
	a_rd13: assert property (p_rd13) else $error("ch2 low readback");
	property p_cmp;
		prox_ch1_valid |-> ##2 prox_done[0] && prox_above[0] == ($past(prox_ch1_result, 2) > $past(prox_ch1_threshold, 1));
	endproperty
	a_cmp: assert property (p_cmp) else $error("ch1 compare");
	property p_irq;
		prox_irq_req == |(prox_done & prox_above);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	c_rd: cover property (reg_rvalid);
	c_irq: cover property (prox_irq_req);
	c_leg: cover property (legacy_compressed && prox_done[0]);
endmodule
bind pth_regs pth_chk i_pth_chk (
	.core_clk           (core_clk),
	.rst                (rst),
	.reg_wr             (reg_wr),
	.reg_rd             (reg_rd),
	.reg_addr           (reg_addr),
	.reg_wdata          (reg_wdata),
	.reg_rdata          (reg_rdata),
	.reg_rvalid         (reg_rvalid),
	.legacy_compressed  (legacy_compressed),
	.prox_ch1_valid     (prox_ch1_valid),
	.prox_ch1_result    (prox_ch1_result),
	.prox_above         (prox_above),
	.prox_done          (prox_done),
	.prox_irq_req       (prox_irq_req),
	.prox_ch1_threshold (prox_ch1_threshold),
	.prox_ch2_threshold (prox_ch2_threshold)
);

// ---- bench/tb_top.sv ----
// Self-checking bench for the threshold bank
`timescale 1ns/100ps
module tb_top;
	reg         core_clk, rst, legacy_compressed;
	reg  [2:0]  vld;
	reg  [15:0] res [0:2];
	wire        reg_wr, reg_rd, reg_rvalid, prox_irq_req;
	wire [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire [2:0]  prox_above, prox_done;
	wire [15:0] th1, th2, th3;
	reg  [8:0]  rv;
	reg  [23:0] rows [0:6];
	integer     n_fail, comparisons, i;
	pth_regs i_pth_regs (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .legacy_compressed(legacy_compressed),
		.prox_ch1_valid(vld[0]), .prox_ch1_result(res[0]), .prox_ch2_valid(vld[1]), .prox_ch2_result(res[1]),
		.prox_ch3_valid(vld[2]), .prox_ch3_result(res[2]), .prox_above(prox_above), .prox_done(prox_done),
		.prox_irq_req(prox_irq_req), .prox_ch1_threshold(th1), .prox_ch2_threshold(th2), .prox_ch3_threshold(th3));
	pth_host i_pth_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	task chk(input [15:0] s, e);
		comparisons = comparisons + 1;
		if (s !== e) begin
			n_fail = n_fail + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task test_done;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task meas(input integer c, input [15:0] r, input a);
		@(negedge core_clk) {vld[c], res[c]} = {1'b1, r};
		@(negedge core_clk) {vld[c], res[c]} = {1'b0, ~r};
		@(negedge core_clk);
		chk({prox_done[c], prox_above[c], prox_irq_req}, {1'b1, a, a});
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#100000 n_fail = n_fail + 1;
		test_done;
	end
	initial begin
		{rst, legacy_compressed, vld, n_fail, comparisons} = {5'h10, 64'h0};
		for (i = 0; i < 3; i = i + 1) res[i] = 16'h0000;
		rows = '{24'h11_a1a1, 24'h12_b2b2, 24'h13_c3c3, 24'h14_d4d4, 24'h15_e5e5, 24'h16_f6f6, 24'h17_5a00};
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		for (i = 0; i < 7; i = i + 1) begin
			i_pth_host.wr(rows[i][23:16], rows[i][15:8]);
			i_pth_host.rd(rows[i][23:16], rv);
			chk(rv, {1'b1, rows[i][7:0]});
		end
		chk(th1, 16'hb2a1);
		chk(th2, 16'hd4c3);
		chk(th3, 16'hf6e5);
		$display("map test done");
		meas(0, 16'hb2a2, 1'b1);
		meas(0, 16'hb2a1, 1'b0);
		meas(1, 16'h0000, 1'b0);
		meas(2, 16'hffff, 1'b1);
		$display("compare test done");
		i_pth_host.wr(8'h11, 8'h00);
		meas(0, 16'hb201, 1'b1);
		i_pth_host.wr(8'h12, 8'h01);
		meas(0, 16'h0101, 1'b1);
		$display("split update test done");
		legacy_compressed = 1'b1;
		i_pth_host.wr(8'h11, 8'h80);
		repeat (2) @(negedge core_clk);
		chk(th1, 16'h0080);
		meas(0, 16'h0081, 1'b1);
		$display("legacy test done");
		@(negedge core_clk) {rst, legacy_compressed} = 2'b10;
		@(negedge core_clk) rst = 1'b0;
		i_pth_host.rd(8'h13, rv);
		chk(rv, 9'h100);
		i_pth_host.rd(8'h15, rv);
		chk(rv, 9'h100);
		$display("reset test done");
		test_done;
	end
endmodule

// ---- hdl/pth_compare.v ----
// One proximity channel threshold comparison stage
`timescale 1ns/100ps

module pth_compare #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             rst,
	// Measurement in
	input  wire             meas_valid,
	input  wire [WIDTH-1:0] meas_result,
	input  wire [WIDTH-1:0] threshold,
	// Outcome
	output reg              above,
	output reg              done
);

	// ----------------------------------------
	// Compare on measurement completion
	// ----------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			above <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= meas_valid;
			if (meas_valid) begin
				// Live threshold used; a half-written pair is compared as is
				above <= (meas_result > threshold);
			end
		end
	end

endmodule

// ---- hdl/pth_map.vh ----
// Register offsets, field layout and reset values of the proximity threshold bank
`ifndef PTH_MAP_VH
`define PTH_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTH_ADDR_P1_LOW   8'h11
`define PTH_ADDR_P1_HIGH  8'h12
`define PTH_ADDR_P2_LOW   8'h13
`define PTH_ADDR_P2_HIGH  8'h14
`define PTH_ADDR_P3_LOW   8'h15
`define PTH_ADDR_P3_HIGH  8'h16

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define PTH_HIGH_MSB      15
`define PTH_HIGH_LSB      8
`define PTH_LOW_MSB       7
`define PTH_LOW_LSB       0
`define PTH_LOW_RESET     8'h00
`define PTH_HIGH_RESET    8'h00
`define PTH_UNMAPPED_READ 8'h00

`endif

// ---- hdl/pth_regs.v ----
// Proximity threshold register bank with per-channel comparison
//
// Operation
// - Ch1 high at 0x12, ch2 low 0x13 high 0x14, ch3 low at 0x15.
// - Each threshold is 16 bits: high register bits 15:8, low register 7:0.
// - Each channel measurement is compared against its own threshold for interrupt decision.
// - Bytes update separately; a measurement between writes sees a mixed threshold.
// - Legacy mode: one 8-bit compressed threshold at the channel low address.
// - Channel two and three low bytes reset to zero.
// - Channel one low byte lives at 0x11.
`timescale 1ns/100ps
`include "pth_map.vh"

module pth_regs #(
	parameter THR_WIDTH = 16
) (
	// Clock and reset
	input  wire                 core_clk,
	input  wire                 rst,
	// Register port from the serial slave
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	input  wire [7:0]           reg_addr,
	input  wire [7:0]           reg_wdata,
	output reg  [7:0]           reg_rdata,
	output reg                  reg_rvalid,
	// Silicon variant select
	input  wire                 legacy_compressed,
	// Channel one measurement
	input  wire                 prox_ch1_valid,
	input  wire [THR_WIDTH-1:0] prox_ch1_result,
	// Channel two measurement
	input  wire                 prox_ch2_valid,
	input  wire [THR_WIDTH-1:0] prox_ch2_result,
	// Channel three measurement
	input  wire                 prox_ch3_valid,
	input  wire [THR_WIDTH-1:0] prox_ch3_result,
	// Threshold outcomes
	output reg  [2:0]           prox_above,
	output reg  [2:0]           prox_done,
	output reg                  prox_irq_req,
	// Current thresholds
	output reg  [THR_WIDTH-1:0] prox_ch1_threshold,
	output reg  [THR_WIDTH-1:0] prox_ch2_threshold,
	output reg  [THR_WIDTH-1:0] prox_ch3_threshold
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg  [7:0]  prox1_thresh_low;
	reg  [7:0]  prox1_thresh_high;
	reg  [7:0]  prox2_thresh_low;
	reg  [7:0]  prox2_thresh_high;
	reg  [7:0]  prox3_thresh_low;
	reg  [7:0]  prox3_thresh_high;
	reg  [7:0]  next_rdata;
	reg  [THR_WIDTH-1:0] next_th1;
	reg  [THR_WIDTH-1:0] next_th2;
	reg  [THR_WIDTH-1:0] next_th3;
	wire [2:0]  cmp_above;
	wire [2:0]  cmp_done;

	// ----------------------------------------
	// Writes, one byte each
	// ----------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			// High bytes have no defined reset; cleared like the low bytes
			prox1_thresh_low  <= `PTH_LOW_RESET;
			prox1_thresh_high <= `PTH_HIGH_RESET;
			prox2_thresh_low  <= `PTH_LOW_RESET;
			prox2_thresh_high <= `PTH_HIGH_RESET;
			prox3_thresh_low  <= `PTH_LOW_RESET;
			prox3_thresh_high <= `PTH_HIGH_RESET;
		end else if (reg_wr) begin
			// Each byte lands at once; no shadow pairing of bytes
			if (reg_addr == `PTH_ADDR_P1_LOW) begin
				prox1_thresh_low <= reg_wdata;
			end else if (reg_addr == `PTH_ADDR_P1_HIGH) begin
				prox1_thresh_high <= reg_wdata;
			end else if (reg_addr == `PTH_ADDR_P2_LOW) begin
				prox2_thresh_low <= reg_wdata;
			end else if (reg_addr == `PTH_ADDR_P2_HIGH) begin
				prox2_thresh_high <= reg_wdata;
			end else if (reg_addr == `PTH_ADDR_P3_LOW) begin
				prox3_thresh_low <= reg_wdata;
			end else if (reg_addr == `PTH_ADDR_P3_HIGH) begin
				prox3_thresh_high <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		// Unmapped addresses read as zero
		next_rdata = `PTH_UNMAPPED_READ;
		if (reg_addr == `PTH_ADDR_P1_LOW) begin
			next_rdata = prox1_thresh_low;
		end else if (reg_addr == `PTH_ADDR_P1_HIGH) begin
			next_rdata = prox1_thresh_high;
		end else if (reg_addr == `PTH_ADDR_P2_LOW) begin
			next_rdata = prox2_thresh_low;
		end else if (reg_addr == `PTH_ADDR_P2_HIGH) begin
			next_rdata = prox2_thresh_high;
		end else if (reg_addr == `PTH_ADDR_P3_LOW) begin
			next_rdata = prox3_thresh_low;
		end else if (reg_addr == `PTH_ADDR_P3_HIGH) begin
			next_rdata = prox3_thresh_high;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ----------------------------------------
	// Threshold assembly
	// ----------------------------------------
	always @* begin
		// Legacy parts keep one compressed byte at the low address; it is
		// passed raw in the low bits and the high registers are ignored
		next_th1 = {THR_WIDTH{1'b0}};
		next_th2 = {THR_WIDTH{1'b0}};
		next_th3 = {THR_WIDTH{1'b0}};
		next_th1[`PTH_LOW_MSB:`PTH_LOW_LSB] = prox1_thresh_low;
		next_th2[`PTH_LOW_MSB:`PTH_LOW_LSB] = prox2_thresh_low;
		next_th3[`PTH_LOW_MSB:`PTH_LOW_LSB] = prox3_thresh_low;
		if (!legacy_compressed) begin
			next_th1[`PTH_HIGH_MSB:`PTH_HIGH_LSB] = prox1_thresh_high;
			next_th2[`PTH_HIGH_MSB:`PTH_HIGH_LSB] = prox2_thresh_high;
			next_th3[`PTH_HIGH_MSB:`PTH_HIGH_LSB] = prox3_thresh_high;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prox_ch1_threshold <= {THR_WIDTH{1'b0}};
			prox_ch2_threshold <= {THR_WIDTH{1'b0}};
			prox_ch3_threshold <= {THR_WIDTH{1'b0}};
		end else begin
			prox_ch1_threshold <= next_th1;
			prox_ch2_threshold <= next_th2;
			prox_ch3_threshold <= next_th3;
		end
	end

	// ----------------------------------------
	// Per-channel comparison
	// ----------------------------------------
	// Comparators take the stored bytes, not the registered pair, so a
	// lone first byte of an update is compared as a mixed threshold
	pth_compare #(.WIDTH(THR_WIDTH)) u_cmp1 (
		.core_clk    (core_clk),
		.rst         (rst),
		.meas_valid  (prox_ch1_valid),
		.meas_result (prox_ch1_result),
		.threshold   (next_th1),
		.above       (cmp_above[0]),
		.done        (cmp_done[0])
	);

	pth_compare #(.WIDTH(THR_WIDTH)) u_cmp2 (
		.core_clk    (core_clk),
		.rst         (rst),
		.meas_valid  (prox_ch2_valid),
		.meas_result (prox_ch2_result),
		.threshold   (next_th2),
		.above       (cmp_above[1]),
		.done        (cmp_done[1])
	);

	pth_compare #(.WIDTH(THR_WIDTH)) u_cmp3 (
		.core_clk    (core_clk),
		.rst         (rst),
		.meas_valid  (prox_ch3_valid),
		.meas_result (prox_ch3_result),
		.threshold   (next_th3),
		.above       (cmp_above[2]),
		.done        (cmp_done[2])
	);

	// ----------------------------------------
	// Outcome registers
	// ----------------------------------------
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prox_above   <= 3'h0;
			prox_done    <= 3'h0;
			prox_irq_req <= 1'b0;
		end else begin
			prox_done    <= cmp_done;
			// A channel keeps its last outcome until it completes again
			if (cmp_done[0]) begin
				prox_above[0] <= cmp_above[0];
			end
			if (cmp_done[1]) begin
				prox_above[1] <= cmp_above[1];
			end
			if (cmp_done[2]) begin
				prox_above[2] <= cmp_above[2];
			end
			prox_irq_req <= |(cmp_done & cmp_above);
		end
	end

endmodule
